// file: lumlb_defs.svh
// Constants for the line unit maintenance loopback block.
`ifndef LUMLB_DEFS_SVH
`define LUMLB_DEFS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define LUMLB_DECODE_OFF      12'h000
`define LUMLB_CONFIG_OFF      12'h004
`define LUMLB_STATUS_OFF      12'h008

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define LUMLB_DECODE_W        8
`define LUMLB_DECODE_RST      8'hb1
`define LUMLB_CFG_VARIANT_BIT 0
`define LUMLB_CONFIG_RST      1'h0
`define LUMLB_ST_MODE_LSB     0
`define LUMLB_ST_LOOP_BIT     2
`define LUMLB_ST_RUN_BIT      3
`define LUMLB_ST_TXCLK_BIT    4
`define LUMLB_ST_RXCLK_BIT    5

// ****************************************************************
// Timing
// ****************************************************************
`define LUMLB_CLK_HZ          40000000
`define LUMLB_RC_HZ           10000
`define LUMLB_RC_HALF_CYC     ((`LUMLB_CLK_HZ) / (2 * `LUMLB_RC_HZ))
`define LUMLB_RC_CNT_W        12

// ****************************************************************
// Synchroniser bit positions
// ****************************************************************
`define LUMLB_SYNC_W          9
`define LUMLB_SY_LOOP         0
`define LUMLB_SY_RUN          1
`define LUMLB_SY_STEP         2
`define LUMLB_SY_MTXCLK       3
`define LUMLB_SY_MRXCLK       4
`define LUMLB_SY_MRXDAT       5
`define LUMLB_SY_ITXCLK       6
`define LUMLB_SY_IRXCLK       7
`define LUMLB_SY_IRXDAT       8

`endif

// file: lumlb_pkg.sv
// Types shared by the line unit maintenance loopback block.
`default_nettype none
package lumlb_pkg;

  // ****************************************************************
  // Operating modes, in the order the decode table codes them
  // ****************************************************************
  typedef enum logic [1:0] {
    LUMLB_NORMAL,
    LUMLB_INT_MAINT,
    LUMLB_SYS_TEST,
    LUMLB_EXT_MAINT
  } lumlb_mode_t;

endpackage : lumlb_pkg
`default_nettype wire

// file: lumlb_proc_model.sv
// Processor-side model driving the maintenance selects and the step clock.
`timescale 1ns/1ps
`default_nettype none
module lumlb_proc_model (
  // Clock, reset and requests from the bench.
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [1:0] sel_i,
  input  wire logic       step_i,
  // Selects and step clock toward the block.
  output logic            loop_select_o,
  output logic            run_flag_o,
  output logic            step_clock_o
);
  // Selects are levels; one request moves the step clock by exactly one edge.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {loop_select_o, run_flag_o, step_clock_o} <= 3'h0;
    end else begin
      {loop_select_o, run_flag_o} <= sel_i;
      step_clock_o <= step_clock_o ^ step_i;
    end
  end
endmodule : lumlb_proc_model
`default_nettype wire

// file: lumlb_sync.sv
// Two-flop synchroniser bank for inputs from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module lumlb_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  // Asynchronous inputs and their synchronised copies.
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  // ****************************************************************
  // One two-flop chain per bit
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_r;
      logic stable_r;
      // The first flop feeds only the second, so metastability never leaks.
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          meta_r   <= 1'b0;
          stable_r <= 1'b0;
        end else begin
          meta_r   <= async_i[g];
          stable_r <= meta_r;
        end
      end
      assign sync_o[g] = stable_r;
    end
  endgenerate

endmodule : lumlb_sync
`default_nettype wire

// file: lumlb_top.sv
// Maintenance mode decode, clock selection and loopback for a synchronous line unit.
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "lumlb_defs.svh"
module lumlb_top
  import lumlb_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // APB register port.
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Mode selects and step clock from the microprocessor.
  input  wire logic        loop_select_i,
  input  wire logic        run_flag_i,
  input  wire logic        step_clock_i,
  // External modem interface pins.
  input  wire logic        modem_tx_clk_i,
  input  wire logic        modem_rx_clk_i,
  input  wire logic        modem_rx_data_i,
  output logic             rts_o,
  output logic             dtr_o,
  output logic             maint_clk_o,
  // Integral modem clocks and data.
  input  wire logic        im_tx_clk_i,
  input  wire logic        im_rx_clk_i,
  input  wire logic        im_rx_data_i,
  // Line unit transmitter and modem control requests.
  input  wire logic        tx_serial_i,
  input  wire logic        rts_req_i,
  input  wire logic        dtr_req_i,
  // Line logic clocks, data and controls.
  output logic             line_tx_clk_o,
  output logic             line_rx_clk_o,
  output logic             rx_data_o,
  output logic             force_transmit_o,
  output logic       [1:0] mode_o
);

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  logic [`LUMLB_SYNC_W-1:0] async_in;
  logic [`LUMLB_SYNC_W-1:0] sync_in;

  // Every pin-side input crosses two flops before any decode looks at it.
  assign async_in = {im_rx_data_i, im_rx_clk_i, im_tx_clk_i,
                     modem_rx_data_i, modem_rx_clk_i, modem_tx_clk_i,
                     step_clock_i, run_flag_i, loop_select_i};

  lumlb_sync #(
    .WIDTH (`LUMLB_SYNC_W)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .async_i (async_in),
    .sync_o  (sync_in)
  );

  // ****************************************************************
  // APB slave and software registers
  // ****************************************************************
  logic [`LUMLB_DECODE_W-1:0] decode_r;
  logic [`LUMLB_DECODE_W-1:0] decode_nxt;
  logic                       variant_r;
  logic                       variant_nxt;
  logic [31:0]                prdata_r;
  logic [31:0]                prdata_nxt;
  logic                       pready_r;
  logic                       pready_nxt;
  logic                       pslverr_r;
  logic                       pslverr_nxt;
  logic [31:0]                status_word;
  logic                       access_done;
  lumlb_mode_t                mode_r;

  // Status shows the decoded mode, the synced selects and both line clocks.
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`LUMLB_ST_MODE_LSB +: 2] = mode_r;
    status_word[`LUMLB_ST_LOOP_BIT]      = sync_in[`LUMLB_SY_LOOP];
    status_word[`LUMLB_ST_RUN_BIT]       = sync_in[`LUMLB_SY_RUN];
    status_word[`LUMLB_ST_TXCLK_BIT]     = line_tx_clk_o;
    status_word[`LUMLB_ST_RXCLK_BIT]     = line_rx_clk_o;
  end

  // The answer comes one cycle into the access phase, so pready is a flop.
  assign access_done = psel_i & penable_i & pready_r;

  // Writes take effect at the edge where pready is seen; read data is loaded at the edge that raises pready.
  always_comb begin
    decode_nxt  = decode_r;
    variant_nxt = variant_r;
    prdata_nxt  = prdata_r;
    pslverr_nxt = 1'b0;
    pready_nxt  = psel_i & penable_i & ~pready_r;
    if (psel_i & penable_i & ~pready_r) begin
      prdata_nxt = 32'h0000_0000;
      if (paddr_i == `LUMLB_DECODE_OFF) begin
        prdata_nxt = {24'h00_0000, decode_r};
      end else if (paddr_i == `LUMLB_CONFIG_OFF) begin
        prdata_nxt = {31'h0000_0000, variant_r};
      end else if (paddr_i == `LUMLB_STATUS_OFF) begin
        prdata_nxt = status_word;
      end else begin
        pslverr_nxt = 1'b1;
      end
    end
    if (access_done & pwrite_i & ~pslverr_r) begin
      if (paddr_i == `LUMLB_DECODE_OFF) begin
        decode_nxt = pwdata_i[`LUMLB_DECODE_W-1:0];
      end else if (paddr_i == `LUMLB_CONFIG_OFF) begin
        variant_nxt = pwdata_i[`LUMLB_CFG_VARIANT_BIT];
      end
    end
    if (access_done) begin
      pslverr_nxt = 1'b0;
    end
  end

  // Register stage of the bus slave.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      decode_r  <= `LUMLB_DECODE_RST;
      variant_r <= `LUMLB_CONFIG_RST;
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      decode_r  <= decode_nxt;
      variant_r <= variant_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata_o  = prdata_r;
  assign pready_o  = pready_r;
  assign pslverr_o = pslverr_r;

  // ****************************************************************
  // Internal RC maintenance clock
  // ****************************************************************
  logic [`LUMLB_RC_CNT_W-1:0] rc_cnt_r;
  logic [`LUMLB_RC_CNT_W-1:0] rc_cnt_nxt;
  logic                       rc_clk_r;
  logic                       rc_clk_nxt;

  // Free-running divider; it runs in every mode so a switch finds it ready.
  always_comb begin
    rc_cnt_nxt = rc_cnt_r + `LUMLB_RC_CNT_W'(1);
    rc_clk_nxt = rc_clk_r;
    if (rc_cnt_r == `LUMLB_RC_CNT_W'(`LUMLB_RC_HALF_CYC - 1)) begin
      rc_cnt_nxt = '0;
      rc_clk_nxt = ~rc_clk_r;
    end
  end

  // Register stage of the divider.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rc_cnt_r <= '0;
      rc_clk_r <= 1'b0;
    end else begin
      rc_cnt_r <= rc_cnt_nxt;
      rc_clk_r <= rc_clk_nxt;
    end
  end

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  lumlb_mode_t mode_nxt;
  logic [1:0]  sel_idx;
  logic [1:0]  sel_prev_r;
  logic [1:0]  sel_prev_nxt;

  // The two selects index the table; each entry is a two-bit mode code.
  assign sel_idx = {sync_in[`LUMLB_SY_LOOP], sync_in[`LUMLB_SY_RUN]};

  // The selects cross the clock boundary bit by bit and may land a cycle
  // apart, so the mode only follows a pair that held for two samples.
  always_comb begin
    sel_prev_nxt = sel_idx;
    mode_nxt     = mode_r;
    if (sel_idx == sel_prev_r) begin
      mode_nxt = lumlb_mode_t'(decode_r[{sel_idx, 1'b0} +: 2]);
    end
  end

  // Register stage of the decoded mode.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sel_prev_r <= 2'h0;
      mode_r     <= LUMLB_NORMAL;
    end else begin
      sel_prev_r <= sel_prev_nxt;
      mode_r     <= mode_nxt;
    end
  end

  // ****************************************************************
  // Clock and interface multiplexers
  // ****************************************************************
  logic txclk_nxt;
  logic rxclk_nxt;
  logic rxdat_nxt;
  logic force_nxt;
  logic rts_nxt;
  logic dtr_nxt;
  logic mclk_nxt;
  logic txclk_r;
  logic rxclk_r;
  logic rxdat_r;
  logic force_r;
  logic rts_r;
  logic dtr_r;
  logic mclk_r;
  logic [1:0] mode_out_r;
  logic       ext_tx_clk;
  logic       ext_rx_clk;
  logic       ext_rx_dat;

  // The variant bit picks which line side serves normal and external modes.
  assign ext_tx_clk = variant_r ? sync_in[`LUMLB_SY_ITXCLK] : sync_in[`LUMLB_SY_MTXCLK];
  assign ext_rx_clk = variant_r ? sync_in[`LUMLB_SY_IRXCLK] : sync_in[`LUMLB_SY_MRXCLK];
  assign ext_rx_dat = variant_r ? sync_in[`LUMLB_SY_IRXDAT] : sync_in[`LUMLB_SY_MRXDAT];

  // Clock source and interface conditioning follow the registered mode.
  always_comb begin
    txclk_nxt = ext_tx_clk;
    rxclk_nxt = ext_rx_clk;
    rxdat_nxt = ext_rx_dat;
    force_nxt = 1'b0;
    rts_nxt   = rts_req_i;
    dtr_nxt   = dtr_req_i;
    mclk_nxt  = 1'b0;
    case (mode_r)
      LUMLB_INT_MAINT: begin
        txclk_nxt = sync_in[`LUMLB_SY_STEP];
        rxclk_nxt = sync_in[`LUMLB_SY_STEP];
        force_nxt = 1'b1;
        rxdat_nxt = tx_serial_i;
        rts_nxt   = 1'b0;
        dtr_nxt   = 1'b0;
      end
      LUMLB_SYS_TEST: begin
        txclk_nxt = rc_clk_r;
        rxclk_nxt = rc_clk_r;
        force_nxt = 1'b1;
        rxdat_nxt = tx_serial_i;
        rts_nxt   = 1'b0;
        dtr_nxt   = 1'b0;
      end
      LUMLB_EXT_MAINT: begin
        // With the variant bit clear the fixture turns the maintenance clock into both modem clocks,
        // so the line clocks stay on the pins and only the source changes.
        mclk_nxt = variant_r ? 1'b0 : rc_clk_r;
        if (variant_r) begin
          txclk_nxt = sync_in[`LUMLB_SY_ITXCLK];
          rxclk_nxt = sync_in[`LUMLB_SY_IRXCLK];
        end
      end
      default: begin
        mclk_nxt = 1'b0;
      end
    endcase
  end

  // Output flops; the control pins change only at a clock edge.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      txclk_r    <= 1'b0;
      rxclk_r    <= 1'b0;
      rxdat_r    <= 1'b0;
      force_r    <= 1'b0;
      rts_r      <= 1'b0;
      dtr_r      <= 1'b0;
      mclk_r     <= 1'b0;
      mode_out_r <= 2'h0;
    end else begin
      txclk_r    <= txclk_nxt;
      rxclk_r    <= rxclk_nxt;
      rxdat_r    <= rxdat_nxt;
      force_r    <= force_nxt;
      rts_r      <= rts_nxt;
      dtr_r      <= dtr_nxt;
      mclk_r     <= mclk_nxt;
      mode_out_r <= mode_r;
    end
  end

  // ****************************************************************
  // Output assignments
  // ****************************************************************
  assign line_tx_clk_o    = txclk_r;
  assign line_rx_clk_o    = rxclk_r;
  assign rx_data_o        = rxdat_r;
  assign force_transmit_o = force_r;
  assign rts_o            = rts_r;
  assign dtr_o            = dtr_r;
  assign maint_clk_o      = mclk_r;
  assign mode_o           = mode_out_r;

endmodule : lumlb_top
`default_nettype wire

// file: lumlb_top_bench.sv
// Self-checking bench for the maintenance loopback block.
`timescale 1ns/1ps
`default_nettype none
`include "lumlb_defs.svh"
module lumlb_top_bench;
  logic        clk_i, rst_b_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic        rts_o, dtr_o, maint_clk_o, line_tx_clk_o, line_rx_clk_o, rx_data_o;
  logic        force_transmit_o, loop_select_i, run_flag_i, step_clock_i, step_rq, fix;
  logic [1:0]  mode_o, sel;
  logic [8:0]  pins;
  logic [15:0] lfsr;
  logic [33:0] notes[$];
  logic [33:0] nq;
  int          miscompares, tests_run;
  // Turnaround fixture: maintenance clock back as modem clocks, data back as data.
  wire mtx = fix ? maint_clk_o : pins[8];
  wire mrx = fix ? maint_clk_o : pins[7];
  wire mrd = fix ? pins[2] : pins[6];
  lumlb_top DUT (.clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .loop_select_i, .run_flag_i, .step_clock_i,
    .modem_tx_clk_i(mtx), .modem_rx_clk_i(mrx), .modem_rx_data_i(mrd),
    .im_tx_clk_i(pins[5]), .im_rx_clk_i(pins[4]), .im_rx_data_i(pins[3]),
    .tx_serial_i(pins[2]), .rts_req_i(pins[1]), .dtr_req_i(pins[0]), .rts_o, .dtr_o,
    .maint_clk_o, .line_tx_clk_o, .line_rx_clk_o, .rx_data_o, .force_transmit_o, .mode_o);
  lumlb_proc_model PROC (.clk_i, .rst_b_i, .sel_i(sel), .step_i(step_rq),
    .loop_select_o(loop_select_i), .run_flag_o(run_flag_i), .step_clock_o(step_clock_i));
  // Free-running 40 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("counts: %0d compared, %0d wrong", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out
  // Note is {read, error, data}; the request is held until ready is seen.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [33:0] note);
    @(posedge clk_i);
    notes.push_back(note);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // Only the watchdog may end a wait for ready.
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  // Each completed transfer is compared with the oldest note.
  always @(posedge clk_i) begin
    if (psel_i && penable_i && pready_o === 1'b1 && notes.size() > 0) begin
      nq = notes.pop_front();
      chk({31'h0, pslverr_o}, {31'h0, nq[32]});
      if (nq[33]) chk(prdata_o, nq[31:0]);
    end
  end
  // Walk all four select codes under one decode table with random line inputs.
  task automatic run_sel(input logic [7:0] tbl, input logic v1);
    logic [1:0] m;
    logic [3:0] e;
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_i);
      sel <= s[1:0];
      lfsr = nxt(lfsr);
      pins <= lfsr[8:0];
      repeat (8) @(posedge clk_i);
      m = tbl[2*s +: 2];
      chk({30'h0, mode_o}, {30'h0, m});
      if (m == 2'h1 || m == 2'h2) e = {3'b100, pins[2]};
      else e = {1'b0, pins[1:0], v1 ? pins[3] : pins[6]};
      chk({28'h0, force_transmit_o, rts_o, dtr_o, rx_data_o}, {28'h0, e});
      if (m == 2'h0 || m == 2'h3)
        chk({30'h0, line_tx_clk_o, line_rx_clk_o}, {30'h0, v1 ? pins[5:4] : pins[8:7]});
    end
  endtask : run_sel
  // Count clock moves over four internal clock half periods.
  task automatic moves(input int etx, input int emc);
    int ntx, nmc;
    logic ltx, lmc;
    repeat (10) @(posedge clk_i);
    ltx = line_tx_clk_o;
    lmc = maint_clk_o;
    ntx = 0;
    nmc = 0;
    repeat (8000) begin
      @(posedge clk_i);
      if (line_tx_clk_o !== ltx) ntx++;
      if (maint_clk_o !== lmc) nmc++;
      ltx = line_tx_clk_o;
      lmc = maint_clk_o;
    end
    chk(ntx, etx);
    chk(nmc, emc);
  endtask : moves
  // Main sequence.
  initial begin
    {rst_b_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {sel, step_rq, fix, pins, miscompares, tests_run} = '0;
    lfsr = 16'd53012;
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    apb(1'b0, `LUMLB_DECODE_OFF, 32'h0, {2'b10, 32'hb1});
    apb(1'b0, `LUMLB_CONFIG_OFF, 32'h0, {2'b10, 32'h0});
    apb(1'b1, `LUMLB_STATUS_OFF, 32'hff, 34'h0);
    apb(1'b0, `LUMLB_STATUS_OFF, 32'h0, {2'b10, 32'h01});
    apb(1'b1, 12'h00c, 32'h3, {2'b01, 32'h0});
    apb(1'b0, 12'h00c, 32'h0, {2'b11, 32'h0});
    $display("test registers done");
    for (int v = 0; v < 2; v++) begin
      apb(1'b1, `LUMLB_CONFIG_OFF, {31'h0, v[0]}, 34'h0);
      run_sel(8'hb1, v[0]);
      lfsr = nxt(lfsr);
      apb(1'b1, `LUMLB_DECODE_OFF, {24'h0, lfsr[7:0]}, 34'h0);
      run_sel(lfsr[7:0], v[0]);
      apb(1'b1, `LUMLB_DECODE_OFF, 32'hb1, 34'h0);
    end
    $display("test mode table done");
    apb(1'b1, `LUMLB_CONFIG_OFF, 32'h0, 34'h0);
    sel <= 2'h0;
    repeat (8) @(posedge clk_i);
    for (int k = 1; k < 5; k++) begin
      step_rq <= 1'b1;
      @(posedge clk_i);
      step_rq <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk({30'h0, line_tx_clk_o, line_rx_clk_o}, {30'h0, {2{k[0]}}});
    end
    sel <= 2'h3;
    moves(4, 0);
    fix <= 1'b1;
    sel <= 2'h2;
    moves(4, 4);
    apb(1'b1, `LUMLB_CONFIG_OFF, 32'h1, 34'h0);
    moves(0, 0);
    $display("test clocks done");
    close_out();
  end
  // Watchdog against a hang.
  initial begin
    repeat (80000) @(posedge clk_i);
    miscompares++;
    close_out();
  end
endmodule : lumlb_top_bench
bind lumlb_top lumlb_chk CHK (.clk_i, .rst_b_i, .psel_i, .penable_i, .pready_o, .pslverr_o,
  .tx_serial_i, .step_clock_i, .rx_data_o, .rts_o, .dtr_o, .maint_clk_o, .line_tx_clk_o,
  .line_rx_clk_o, .force_transmit_o, .mode_o);
`default_nettype wire

// file: lumlb_top_sva.sv
// Concurrent checks on the ports of the maintenance loopback block.
`timescale 1ns/1ps
`default_nettype none
module lumlb_chk (
  // Clock, reset and bus answer.
  input wire logic       clk_i,
  input wire logic       rst_b_i,
  input wire logic       psel_i,
  input wire logic       penable_i,
  input wire logic       pready_o,
  input wire logic       pslverr_o,
  // Line side.
  input wire logic       tx_serial_i,
  input wire logic       step_clock_i,
  input wire logic       rx_data_o,
  input wire logic       rts_o,
  input wire logic       dtr_o,
  input wire logic       maint_clk_o,
  input wire logic       line_tx_clk_o,
  input wire logic       line_rx_clk_o,
  input wire logic       force_transmit_o,
  input wire logic [1:0] mode_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [11:0] gap_r;
  logic [1:0]  arm_r;
  // Gap since the line clock last moved; the first two moves in system test are skipped.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap_r <= 12'h000;
      arm_r <= 2'h0;
    end else begin
      gap_r <= $changed(line_tx_clk_o) ? 12'h000 : gap_r + 12'h001;
      arm_r <= (mode_o != 2'h2) ? 2'h0 :
               arm_r + {1'b0, $changed(line_tx_clk_o) && arm_r != 2'h2};
    end
  end
  sequence s_access;
    psel_i && penable_i && !pready_o;
  endsequence
  sequence s_held_loop;
    mode_o inside {2'h1, 2'h2} && $past(mode_o) == mode_o;
  endsequence
  // Mode-dependent controls.
  a_force_on: assert property (mode_o inside {2'h1, 2'h2} |-> force_transmit_o)
    else $error("force transmit low in a looped mode");
  a_force_off: assert property (mode_o inside {2'h0, 2'h3} |-> !force_transmit_o)
    else $error("force transmit high outside looped modes");
  a_ctrl_off: assert property (mode_o inside {2'h1, 2'h2} |-> !rts_o && !dtr_o)
    else $error("modem controls on in a looped mode");
  a_loop_data: assert property (s_held_loop |-> rx_data_o == $past(tx_serial_i))
    else $error("receiver data not the looped transmit data");
  a_step_clock: assert property (mode_o == 2'h1 && $past(mode_o, 3) == 2'h1 |->
    line_tx_clk_o == $past(step_clock_i, 3) && line_rx_clk_o == line_tx_clk_o)
    else $error("line clocks do not follow the step clock");
  a_rc_period: assert property (mode_o == 2'h2 && arm_r == 2'h2 &&
    $changed(line_tx_clk_o) |-> gap_r == 12'd1999)
    else $error("internal clock half period is not 2000 cycles");
  a_maint_quiet: assert property (mode_o != 2'h3 && $past(mode_o) != 2'h3 |-> !maint_clk_o)
    else $error("maintenance clock driven outside external mode");
  // Bus answer timing.
  a_ready_wait: assert property (s_access |=> pready_o ##1 !pready_o)
    else $error("ready not a single pulse after one wait state");
  a_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
endmodule : lumlb_chk
`default_nettype wire
